// *** design/dma_evq_pkg.sv ***
// How it works
// - Region evaluate write re-pulses pending completion interrupt
// - Region evaluate ignores region access masks
// - Error evaluate write re-pulses pending error interrupt
// - Channel missed events latch, feed error interrupt
// - Quick-channel missed events latch, feed error
// - Queue threshold exceed latches per-queue error bit
// - Over 63 outstanding codes latches error
// - Error interrupt has no mask
// - Error pulse on none-to-some transition or on evaluate write
// - Queue holds 16; full queue refuses event
// - Queue n feeds only transfer engine n
// - Append at tail, dequeue head when engine ready
// - Lowest-numbered ready queue dequeues first
// - Entries read-only, show kind and channel
// - Per-channel programmable queue selection
// - Idle queue and engine, no other dequeue in that cycle: event bypasses queue
// - Circular entries keep dequeued history readable
// - Status shows head pointer and valid count
// - Completion pulse on empty-to-nonempty enabled set
// - Region condition is pending, enable, mask
// - Clear write of one clears pending bit
`default_nettype none

package dma_evq_pkg;
    localparam int NREGION = 2;
    localparam int NQ = 3;
    localparam int QDEPTH = 16;
    localparam int NCH = 64;
    localparam int NQCH = 8;
    localparam int OUTST_MAX = 63;
    localparam int AW = 13;

    // Interrupt block, global at 0x000, region r at 0x1000 + r * 0x100
    localparam logic [7:0] OFF_PEND_LO = 8'h00;
    localparam logic [7:0] OFF_PEND_HI = 8'h04;
    localparam logic [7:0] OFF_EN_LO = 8'h08;
    localparam logic [7:0] OFF_EN_HI = 8'h0C;
    localparam logic [7:0] OFF_CLR_LO = 8'h10;
    localparam logic [7:0] OFF_CLR_HI = 8'h14;
    localparam logic [7:0] OFF_ENSET_LO = 8'h18;
    localparam logic [7:0] OFF_ENSET_HI = 8'h1C;
    localparam logic [7:0] OFF_ENCLR_LO = 8'h20;
    localparam logic [7:0] OFF_ENCLR_HI = 8'h24;
    localparam logic [7:0] OFF_REVAL = 8'h28;
    localparam logic [3:0] REGION_SEL_BIT = 4'hC;
    // Global registers
    localparam logic [AW-1:0] OFF_MISS_LO = 13'h0040;
    localparam logic [AW-1:0] OFF_MISS_HI = 13'h0044;
    localparam logic [AW-1:0] OFF_QMISS = 13'h0048;
    localparam logic [AW-1:0] OFF_CONTROLLER_ERROR_REG = 13'h004C;
    localparam logic [AW-1:0] OFF_ERROR_IRQ_REEVALUATE_REG = 13'h0050;
    localparam logic [AW-1:0] OFF_OUTST = 13'h0054;
    localparam logic [AW-1:0] OFF_MASK_BASE = 13'h0080;
    localparam logic [AW-1:0] OFF_DQSEL_BASE = 13'h0100;
    localparam logic [AW-1:0] OFF_QQSEL = 13'h0120;
    localparam logic [AW-1:0] OFF_QSTAT_BASE = 13'h0140;
    localparam logic [AW-1:0] OFF_ENTRY_BASE = 13'h0200;
    // Field positions
    localparam int REEVALUATE_TRIGGER_BIT_BIT = 0;
    localparam int CONTROLLER_ERROR_REG_TCC_BIT = 16;
    localparam int QSTAT_CNT_POS = 8;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        KIND_MANUAL = 2'h0,
        KIND_EVENT = 2'h1,
        KIND_CHAIN = 2'h2,
        KIND_AUTO = 2'h3
    } evt_kind_t;

    // Queue entry as held and as submitted
    typedef struct packed {
        logic quick;
        evt_kind_t kind;
        logic [5:0] num;
    } evt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [NCH-1:0] pend;
        logic [NCH-1:0] en;
        logic [NREGION-1:0][NCH-1:0] mask;
        logic [NCH-1:0] miss;
        logic [NQCH-1:0] qmiss;
        logic [NQ-1:0] thr_err;
        logic tcc_err;
        logic [6:0] outst;
        logic [NCH-1:0][1:0] dqsel;
        logic [NQCH-1:0][1:0] qqsel;
        logic [NQ-1:0][QDEPTH-1:0] [$bits(evt_t)-1:0] ram;
        logic [NQ-1:0][3:0] head;
        logic [NQ-1:0][4:0] cnt;
        logic [NQ-1:0] full;
        logic [NREGION-1:0] cprev;
        logic eprev;
        logic [NREGION-1:0] cirq;
        logic eirq;
        logic [NQ-1:0] req_valid;
        evt_t req_entry;
        logic [31:0] rdata;
    } state_t;
endpackage

`default_nettype wire

// *** design/dma_evq_ctrl.sv ***
`default_nettype none

module dma_evq_ctrl
    import dma_evq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire bus_req_t bus,
    output logic [31:0] rdata,
    // Completion codes and outstanding tracking
    input wire logic cc_valid,
    input wire logic [5:0] cc_code,
    input wire logic tr_issue_expect,
    // Error sources
    input wire logic [NCH-1:0] dma_miss_in,
    input wire logic [NQCH-1:0] quick_miss_in,
    input wire logic [NQ-1:0] thr_exceed,
    // Prioritized event in
    input wire logic evt_valid,
    input wire evt_t evt_in,
    output logic [NQ-1:0] queue_full,
    // Transfer engines
    input wire logic [NQ-1:0] tc_ready,
    input wire logic [NQ-1:0] tc_idle,
    output logic [NQ-1:0] req_valid,
    output evt_t req_entry,
    // Interrupts
    output logic [NREGION-1:0] completion_irq_out,
    output logic error_irq_out
);
    state_t s_q, s_d;
    logic [NREGION-1:0] ccond;
    logic econd;
    logic [NREGION-1:0] reevaluate_trigger_bit_wr;
    logic error_irq_reevaluate_reg_wr;
    logic [NQ-1:0] deq;
    logic bypass;
    logic enq;
    logic [1:0] tq;

    always_comb begin
        logic [NCH-1:0] set_pend, clr_pend, en_set, en_clr, gate, miss_clr;
        logic [NQCH-1:0] qmiss_clr;
        logic [31:0] controller_error_reg_clr, rd_val, controller_error_reg_val;
        logic [3:0] rgn, tail;
        logic [7:0] off;
        logic int_sel, shadow, done;
        logic [1:0] q, eq;
        logic [3:0] ei;
        logic inc;
        s_d = s_q;
        set_pend = '0;
        clr_pend = '0;
        en_set = '0;
        en_clr = '0;
        miss_clr = '0;
        qmiss_clr = '0;
        controller_error_reg_clr = '0;
        rd_val = '0;
        reevaluate_trigger_bit_wr = '0;
        error_irq_reevaluate_reg_wr = 1'b0;
        deq = '0;
        bypass = 1'b0;
        enq = 1'b0;
        tq = '0;
        tail = '0;
        done = 1'b0;
        q = '0;
        eq = bus.addr[7:6];
        ei = bus.addr[5:2];
        inc = 1'b0;
        rgn = bus.addr[11:8];
        off = bus.addr[7:0];
        shadow = bus.addr[REGION_SEL_BIT];
        int_sel = shadow ? (rgn < 4'(NREGION)) : (rgn == 4'h0 && off < OFF_REVAL);
        gate = '1;
        if (shadow && rgn < 4'(NREGION))
            gate = s_q.mask[rgn[$clog2(NREGION)-1:0]];
        // Conditions come from registered state
        for (int r = 0; r < NREGION; r++) begin
            ccond[r] = |(s_q.pend & s_q.en & s_q.mask[r]);
        end
        controller_error_reg_val = RST_ZERO;
        controller_error_reg_val[NQ-1:0] = s_q.thr_err;
        controller_error_reg_val[CONTROLLER_ERROR_REG_TCC_BIT] = s_q.tcc_err;
        econd = (|s_q.miss) || (|s_q.qmiss) || (|controller_error_reg_val);

        if (cc_valid)
            set_pend[cc_code] = 1'b1;

        if (bus.wr && int_sel) begin
            case (off)
                OFF_CLR_LO: clr_pend[31:0] = bus.wdata & gate[31:0];
                OFF_CLR_HI: clr_pend[63:32] = bus.wdata & gate[63:32];
                OFF_ENSET_LO: en_set[31:0] = bus.wdata & gate[31:0];
                OFF_ENSET_HI: en_set[63:32] = bus.wdata & gate[63:32];
                OFF_ENCLR_LO: en_clr[31:0] = bus.wdata & gate[31:0];
                OFF_ENCLR_HI: en_clr[63:32] = bus.wdata & gate[63:32];
                // evaluate write is not gated by the mask
                OFF_REVAL: if (shadow) reevaluate_trigger_bit_wr[rgn[$clog2(NREGION)-1:0]] = bus.wdata[REEVALUATE_TRIGGER_BIT_BIT];
                default: ;
            endcase
        end
        if (bus.wr && !shadow) begin
            case (bus.addr)
                OFF_MISS_LO: miss_clr[31:0] = bus.wdata;
                OFF_MISS_HI: miss_clr[63:32] = bus.wdata;
                OFF_QMISS: qmiss_clr = bus.wdata[NQCH-1:0];
                OFF_CONTROLLER_ERROR_REG: controller_error_reg_clr = bus.wdata;
                OFF_ERROR_IRQ_REEVALUATE_REG: error_irq_reevaluate_reg_wr = bus.wdata[REEVALUATE_TRIGGER_BIT_BIT];
                OFF_QQSEL: begin
                    for (int c = 0; c < NQCH; c++)
                        s_d.qqsel[c] = bus.wdata[4*c +: 2];
                end
                default: ;
            endcase
            for (int r = 0; r < NREGION; r++) begin
                if (bus.addr == OFF_MASK_BASE + AW'(8 * r))
                    s_d.mask[r][31:0] = bus.wdata;
                if (bus.addr == OFF_MASK_BASE + AW'(8 * r + 4))
                    s_d.mask[r][63:32] = bus.wdata;
            end
            for (int w = 0; w < NCH / 8; w++) begin
                if (bus.addr == OFF_DQSEL_BASE + AW'(4 * w)) begin
                    for (int c = 0; c < 8; c++)
                        s_d.dqsel[8*w+c] = bus.wdata[4*c +: 2];
                end
            end
        end

        s_d.pend = (s_q.pend & ~clr_pend) | set_pend;
        s_d.en = (s_q.en | en_set) & ~en_clr;
        s_d.miss = (s_q.miss & ~miss_clr) | dma_miss_in;
        s_d.qmiss = (s_q.qmiss & ~qmiss_clr) | quick_miss_in;
        s_d.thr_err = (s_q.thr_err & ~controller_error_reg_clr[NQ-1:0]) | thr_exceed;
        s_d.tcc_err = s_q.tcc_err & ~controller_error_reg_clr[CONTROLLER_ERROR_REG_TCC_BIT];
        if (tr_issue_expect && !cc_valid) begin
            if (s_q.outst == 7'(OUTST_MAX))
                s_d.tcc_err = 1'b1;
            else
                s_d.outst = s_q.outst + 7'h01;
        end else if (!tr_issue_expect && cc_valid && s_q.outst != 7'h00) begin
            s_d.outst = s_q.outst - 7'h01;
        end

        // pulse on rise or on evaluate
        for (int r = 0; r < NREGION; r++) begin
            s_d.cprev[r] = ccond[r];
            s_d.cirq[r] = ccond[r] && (!s_q.cprev[r] || reevaluate_trigger_bit_wr[r]);
        end
        s_d.eprev = econd;
        s_d.eirq = econd && (!s_q.eprev || error_irq_reevaluate_reg_wr);

        // lowest ready queue wins the submission slot
        // head leaves only when engine ready
        s_d.req_valid = '0;
        for (int n = 0; n < NQ; n++) begin
            if (!done && s_q.cnt[n] != 5'h00 && tc_ready[n]) begin
                deq[n] = 1'b1;
                done = 1'b1;
                q = 2'(n);
            end
        end
        tq = evt_in.quick ? s_q.qqsel[evt_in.num[2:0]] : s_q.dqsel[evt_in.num];
        if (tq > 2'(NQ - 1))
            tq = 2'(NQ - 1);
        if (evt_valid && !s_q.full[tq]) begin
            if (!done && s_q.cnt[tq] == 5'h00 && tc_idle[tq] && tc_ready[tq])
                bypass = 1'b1;
            else
                enq = 1'b1;
        end
        // queue n drives engine n only
        if (done) begin
            s_d.req_valid[q] = 1'b1;
            s_d.req_entry = evt_t'(s_q.ram[q][s_q.head[q]]);
            s_d.head[q] = s_q.head[q] + 4'h1;
        end else if (bypass) begin
            s_d.req_valid[tq] = 1'b1;
            s_d.req_entry = evt_in;
        end
        if (enq) begin
            tail = s_q.head[tq] + s_q.cnt[tq][3:0];
            s_d.ram[tq][tail] = evt_in;
        end
        for (int n = 0; n < NQ; n++) begin
            inc = enq && tq == 2'(n);
            if (inc && !deq[n])
                s_d.cnt[n] = s_q.cnt[n] + 5'h01;
            else if (!inc && deq[n])
                s_d.cnt[n] = s_q.cnt[n] - 5'h01;
            s_d.full[n] = s_d.cnt[n] == 5'(QDEPTH);
        end

        // Read data in the next cycle only
        if (bus.rd && int_sel) begin
            case (off)
                OFF_PEND_LO: rd_val = s_q.pend[31:0] & gate[31:0];
                OFF_PEND_HI: rd_val = s_q.pend[63:32] & gate[63:32];
                OFF_EN_LO: rd_val = s_q.en[31:0] & gate[31:0];
                OFF_EN_HI: rd_val = s_q.en[63:32] & gate[63:32];
                default: rd_val = RST_ZERO;
            endcase
        end else if (bus.rd && !shadow) begin
            case (bus.addr)
                OFF_MISS_LO: rd_val = s_q.miss[31:0];
                OFF_MISS_HI: rd_val = s_q.miss[63:32];
                OFF_QMISS: rd_val = {24'h000000, s_q.qmiss};
                OFF_CONTROLLER_ERROR_REG: rd_val = controller_error_reg_val;
                OFF_OUTST: rd_val = {25'h0000000, s_q.outst};
                OFF_QQSEL: begin
                    for (int c = 0; c < NQCH; c++)
                        rd_val[4*c +: 2] = s_q.qqsel[c];
                end
                default: rd_val = RST_ZERO;
            endcase
            for (int r = 0; r < NREGION; r++) begin
                if (bus.addr == OFF_MASK_BASE + AW'(8 * r))
                    rd_val = s_q.mask[r][31:0];
                if (bus.addr == OFF_MASK_BASE + AW'(8 * r + 4))
                    rd_val = s_q.mask[r][63:32];
            end
            for (int w = 0; w < NCH / 8; w++) begin
                if (bus.addr == OFF_DQSEL_BASE + AW'(4 * w)) begin
                    for (int c = 0; c < 8; c++)
                        rd_val[4*c +: 2] = s_q.dqsel[8*w+c];
                end
            end
            for (int n = 0; n < NQ; n++) begin
                if (bus.addr == OFF_QSTAT_BASE + AW'(4 * n)) begin
                    rd_val[3:0] = s_q.head[n];
                    rd_val[QSTAT_CNT_POS +: 5] = s_q.cnt[n];
                end
            end
            if (bus.addr[AW-1:8] == OFF_ENTRY_BASE[AW-1:8] && eq < 2'(NQ))
                rd_val = {23'h000000, s_q.ram[eq][ei]};
        end
        s_d.rdata = rd_val;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign completion_irq_out = s_q.cirq;
    assign error_irq_out = s_q.eirq;
    assign req_valid = s_q.req_valid;
    assign req_entry = s_q.req_entry;
    assign queue_full = s_q.full;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_reevaluate_trigger_bit_hit;
        reevaluate_trigger_bit_wr[0] && ccond[0];
    endsequence
    sequence s_irq_once;
        completion_irq_out[0] ##1 !completion_irq_out[0];
    endsequence

    // A second evaluate write may legally pulse again
    property p_reevaluate_trigger_bit_pulse;
        s_reevaluate_trigger_bit_hit ##1 !reevaluate_trigger_bit_wr[0] |-> s_irq_once;
    endproperty
    a_reevaluate_trigger_bit_pulse: assert property (p_reevaluate_trigger_bit_pulse) else $error("evaluate gave no pulse");

    property p_reevaluate_trigger_bit_quiet;
        (reevaluate_trigger_bit_wr[0] && !ccond[0]) |=> !completion_irq_out[0];
    endproperty
    a_reevaluate_trigger_bit_quiet: assert property (p_reevaluate_trigger_bit_quiet) else $error("pulse without pending");

    property p_comp_rise;
        (ccond[0] && !$past(ccond[0])) |=> completion_irq_out[0];
    endproperty
    a_comp_rise: assert property (p_comp_rise) else $error("no pulse on rise");

    property p_err_once;
        ($past(econd) && econd && !error_irq_reevaluate_reg_wr) |=> !error_irq_out;
    endproperty
    a_err_once: assert property (p_err_once) else $error("extra error pulse");

    property p_error_irq_reevaluate_reg;
        (error_irq_reevaluate_reg_wr && econd) |=> error_irq_out;
    endproperty
    a_error_irq_reevaluate_reg: assert property (p_error_irq_reevaluate_reg) else $error("error evaluate ignored");

    property p_miss_latch;
        (dma_miss_in != '0) |=> ((s_q.miss & $past(dma_miss_in)) == $past(dma_miss_in)) && econd;
    endproperty
    a_miss_latch: assert property (p_miss_latch) else $error("missed event lost");

    property p_tcc_err;
        (s_q.outst == 7'(OUTST_MAX) && tr_issue_expect && !cc_valid) |=> s_q.tcc_err;
    endproperty
    a_tcc_err: assert property (p_tcc_err) else $error("outstanding overflow lost");

    property p_prio;
        (s_q.cnt[0] != 5'h00 && tc_ready[0]) |=> req_valid == 3'b001;
    endproperty
    a_prio: assert property (p_prio) else $error("queue 0 not first");

    property p_depth;
        (s_q.cnt[1] <= 5'(QDEPTH)) && (s_q.full[1] == (s_q.cnt[1] == 5'(QDEPTH)));
    endproperty
    a_depth: assert property (p_depth) else $error("queue depth broken");

    property p_bypass;
        bypass |=> (req_valid != '0) && s_q.cnt == $past(s_q.cnt);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass logged");

    property p_clear;
        (bus.wr && bus.addr == {5'h00, OFF_CLR_LO} && bus.wdata[5] && !(cc_valid && cc_code == 6'h05))
            |=> !s_q.pend[5];
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    property p_reevaluate_trigger_bit_nogate;
        (bus.wr && bus.addr == {1'b1, 4'h0, OFF_REVAL} && bus.wdata[REEVALUATE_TRIGGER_BIT_BIT] && ccond[0])
            |=> completion_irq_out[0];
    endproperty
    a_reevaluate_trigger_bit_nogate: assert property (p_reevaluate_trigger_bit_nogate) else $error("evaluate blocked by mask");

    property p_thr_latch;
        (thr_exceed != '0) |=> ((s_q.thr_err & $past(thr_exceed)) == $past(thr_exceed)) && econd;
    endproperty
    a_thr_latch: assert property (p_thr_latch) else $error("threshold error lost");

    property p_full_hold;
        (evt_valid && tq == 2'h1 && s_q.full[1] && !deq[1]) |=> s_q.cnt[1] == 5'(QDEPTH);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("event taken while full");

    property p_head_step;
        deq[1] |=> s_q.head[1] == $past(s_q.head[1]) + 4'h1;
    endproperty
    a_head_step: assert property (p_head_step) else $error("head did not advance");

    property p_err_single;
        (error_irq_out && !error_irq_reevaluate_reg_wr) |=> !error_irq_out;
    endproperty
    a_err_single: assert property (p_err_single) else $error("error pulse too long");
endmodule // dma_evq_ctrl

`default_nettype wire

// *** test/dma_tc_model.sv ***
`default_nettype none

module dma_tc_model
    import dma_evq_pkg::*;
#(
    parameter int BUSY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Requests and stall control
    input wire logic [NQ-1:0] req_valid,
    input wire logic [NQ-1:0] hold,
    // Engine status
    output logic [NQ-1:0] tc_ready,
    output logic [NQ-1:0] tc_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    int busy [NQ];

    always @(posedge clk or negedge nrst) begin
        for (int n = 0; n < NQ; n++) begin
            if (!nrst)
                busy[n] <= 0;
            else if (req_valid[n])
                busy[n] <= BUSY;
            else if (busy[n] > 0)
                busy[n] <= busy[n] - 1;
        end
    end

    // Pipelined: takes a new request before it has gone idle
    always_comb begin
        for (int n = 0; n < NQ; n++) begin
            tc_ready[n] = !hold[n] && busy[n] < 2;
            tc_idle[n] = !hold[n] && busy[n] == 0;
        end
    end
endmodule // dma_tc_model

`default_nettype wire

// *** test/tb_dma_interrupt_error_event_queues.sv ***
`default_nettype none

module tb_dma_interrupt_error_event_queues
    import dma_evq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    bus_req_t bus;
    logic [31:0] rdata;
    logic cc_valid, tr_issue_expect, evt_valid, error_irq_out;
    logic [5:0] cc_code;
    logic [NCH-1:0] dma_miss_in;
    logic [NQCH-1:0] quick_miss_in;
    logic [NQ-1:0] thr_exceed, queue_full, tc_ready, tc_idle, req_valid, hold;
    evt_t evt_in, req_entry;
    logic [NREGION-1:0] completion_irq_out;
    int err_total, checks, ecnt;
    int ccnt [NREGION];
    evt_t exp_q [NQ][$];
    evt_t got_q [NQ][$];
    int order [$];

    dma_evq_ctrl u_dma_evq_ctrl (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .cc_valid(cc_valid), .cc_code(cc_code), .tr_issue_expect(tr_issue_expect),
        .dma_miss_in(dma_miss_in), .quick_miss_in(quick_miss_in), .thr_exceed(thr_exceed),
        .evt_valid(evt_valid), .evt_in(evt_in), .queue_full(queue_full),
        .tc_ready(tc_ready), .tc_idle(tc_idle), .req_valid(req_valid),
        .req_entry(req_entry), .completion_irq_out(completion_irq_out),
        .error_irq_out(error_irq_out));
    dma_tc_model u_dma_tc_model (.clk(clk), .nrst(nrst), .req_valid(req_valid),
        .hold(hold), .tc_ready(tc_ready), .tc_idle(tc_idle));

    always #50 clk = ~clk;

    // Count pulses and capture every submitted request
    always @(posedge clk) begin
        if (error_irq_out === 1'b1)
            ecnt++;
        for (int r = 0; r < NREGION; r++)
            if (completion_irq_out[r] === 1'b1)
                ccnt[r]++;
        for (int n = 0; n < NQ; n++) begin
            if (req_valid[n] === 1'b1) begin
                got_q[n].push_back(req_entry);
                order.push_back(n);
            end
        end
    end

    task automatic finish_test();
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rdchk(input string what, input logic [AW-1:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus <= '0;
        #1 chk(what, e, rdata);
    endtask

    task automatic pulse(input logic [5:0] c, input logic is_cc, input logic iss,
                         input logic [63:0] dm, input logic [7:0] qm, input logic [2:0] th);
        @(posedge clk);
        cc_valid <= is_cc;
        cc_code <= c;
        tr_issue_expect <= iss;
        dma_miss_in <= dm;
        quick_miss_in <= qm;
        thr_exceed <= th;
        @(posedge clk);
        {cc_valid, tr_issue_expect, dma_miss_in, quick_miss_in, thr_exceed} <= '0;
    endtask

    task automatic send(input evt_t e);
        @(posedge clk);
        evt_valid <= 1'b1;
        evt_in <= e;
        @(posedge clk);
        evt_valid <= 1'b0;
    endtask

    function automatic logic [AW-1:0] raddr(input int r, input logic [7:0] off);
        return 13'h1000 + 13'(r * 256) + 13'(off);
    endfunction

    function automatic logic [AW-1:0] eaddr(input int n, input int e);
        return OFF_ENTRY_BASE + 13'(n * 64 + e * 4);
    endfunction

    initial begin
        tick(20000);
        err_total++;
        finish_test();
    end

    initial begin
        int b;
        logic [63:0] m;
        evt_t e;
        bus = '0;
        {cc_valid, tr_issue_expect, evt_valid, cc_code, evt_in} = '0;
        {dma_miss_in, quick_miss_in, thr_exceed} = '0;
        hold = '1;
        b = $urandom(32'hB98C);
        tick(3);
        nrst <= 1'b1;
        rdchk("pend reset", {5'h00, OFF_PEND_LO}, RST_ZERO);
        rdchk("qstat reset", OFF_QSTAT_BASE, RST_ZERO);
        // Error interrupt path
        b = $urandom_range(63);
        m = 64'h1 << b;
        pulse(6'h00, 1'b0, 1'b0, m, 8'h00, 3'h0);
        tick(4);
        chk("err pulse", 32'h1, ecnt);
        rdchk("miss lo", OFF_MISS_LO, m[31:0]);
        rdchk("miss hi", OFF_MISS_HI, m[63:32]);
        pulse(6'h00, 1'b0, 1'b0, 64'h1 << ((b + 1) % 64), 8'h00, 3'h0);
        tick(4);
        chk("err no repulse", 32'h1, ecnt);
        wr(OFF_ERROR_IRQ_REEVALUATE_REG, 32'h0000_0001);
        tick(3);
        chk("err reevaluate_trigger_bit", 32'h2, ecnt);
        wr(OFF_MISS_LO, 32'hFFFF_FFFF);
        wr(OFF_MISS_HI, 32'hFFFF_FFFF);
        pulse(6'h00, 1'b0, 1'b0, 64'h0, 8'h1 << (b % 8), 3'h0);
        tick(4);
        chk("quick err", 32'h3, ecnt);
        rdchk("qmiss", OFF_QMISS, 32'(8'h1 << (b % 8)));
        wr(OFF_QMISS, 32'hFFFF_FFFF);
        pulse(6'h00, 1'b0, 1'b0, 64'h0, 8'h00, 3'h5);
        tick(4);
        chk("thr err", 32'h4, ecnt);
        rdchk("controller_error_reg thr", OFF_CONTROLLER_ERROR_REG, 32'h0000_0005);
        wr(OFF_CONTROLLER_ERROR_REG, 32'hFFFF_FFFF);
        repeat (64) pulse(6'h00, 1'b0, 1'b1, 64'h0, 8'h00, 3'h0);
        rdchk("outst", OFF_OUTST, 32'(OUTST_MAX));
        rdchk("controller_error_reg code", OFF_CONTROLLER_ERROR_REG, 32'h1 << CONTROLLER_ERROR_REG_TCC_BIT);
        chk("code err pulse", 32'h5, ecnt);
        wr(OFF_CONTROLLER_ERROR_REG, 32'hFFFF_FFFF);
        // Completion interrupts; mask bit 0 clear, so eval0 shows that evaluate is not gated
        wr({5'h00, OFF_ENSET_LO}, 32'h0000_0060);
        wr(OFF_MASK_BASE, 32'h0000_0060);
        pulse(6'h05, 1'b1, 1'b0, 64'h0, 8'h00, 3'h0);
        tick(4);
        chk("irq0", 32'h1, ccnt[0]);
        chk("irq1", 32'h0, ccnt[1]);
        pulse(6'h06, 1'b1, 1'b0, 64'h0, 8'h00, 3'h0);
        tick(4);
        chk("irq0 no repulse", 32'h1, ccnt[0]);
        rdchk("pend", {5'h00, OFF_PEND_LO}, 32'h0000_0060);
        wr(raddr(0, OFF_REVAL), 32'h0000_0001);
        tick(3);
        chk("eval0", 32'h2, ccnt[0]);
        wr(raddr(1, OFF_REVAL), 32'h0000_0001);
        tick(3);
        chk("eval1", 32'h0, ccnt[1]);
        chk("reevaluate_trigger_bit own", 32'h2, ccnt[0]);
        rdchk("reevaluate_trigger_bit read", raddr(0, OFF_REVAL), RST_ZERO);
        wr(raddr(1, OFF_CLR_LO), 32'h0000_0040);
        wr({5'h00, OFF_CLR_LO}, 32'h0000_0020);
        rdchk("pend clr", {5'h00, OFF_PEND_LO}, 32'h0000_0040);
        wr(raddr(0, OFF_CLR_LO), 32'h0000_0040);
        rdchk("pend empty", {5'h00, OFF_PEND_LO}, RST_ZERO);
        pulse(6'h06, 1'b1, 1'b0, 64'h0, 8'h00, 3'h0);
        tick(4);
        chk("irq0 rearm", 32'h3, ccnt[0]);
        // Queues with all engines stalled
        wr(OFF_DQSEL_BASE, 32'h0000_0210);
        wr(OFF_QQSEL, 32'h0000_0001);
        for (int i = 0; i < 20; i++) begin
            e.quick = 1'($urandom_range(1));
            e.num = e.quick ? 6'h00 : 6'h01;
            e.kind = evt_kind_t'($urandom_range(3));
            send(e);
            if (i < QDEPTH)
                exp_q[1].push_back(e);
        end
        chk("full", 32'h1, 32'(queue_full[1]));
        for (int i = 0; i < 3; i++) begin
            e = '{quick: 1'b0, kind: evt_kind_t'($urandom_range(3)), num: 6'(8 + i)};
            send(e);
            exp_q[0].push_back(e);
        end
        rdchk("qstat1", OFF_QSTAT_BASE + 13'h4, 32'(QDEPTH) << QSTAT_CNT_POS);
        rdchk("entry", eaddr(1, 3), 32'(exp_q[1][3]));
        wr(eaddr(1, 3), 32'h0000_01FF);
        rdchk("entry ro", eaddr(1, 3), 32'(exp_q[1][3]));
        @(posedge clk);
        hold <= '0;
        for (int k = 0; k < 200 && got_q[1].size() < QDEPTH; k++)
            @(posedge clk);
        if (got_q[1].size() != QDEPTH || got_q[0].size() != 3) begin
            chk("drain", {16'(QDEPTH), 16'h0003},
                {16'(got_q[1].size()), 16'(got_q[0].size())});
            finish_test();
        end
        chk("first queue", 32'h0, 32'(order[0]));
        for (int n = 0; n < 2; n++)
            for (int i = 0; i < exp_q[n].size(); i++)
                chk("request", 32'(exp_q[n][i]), 32'(got_q[n][i]));
        rdchk("qstat0", OFF_QSTAT_BASE, 32'h0000_0003);
        rdchk("history", eaddr(0, 1), 32'(exp_q[0][1]));
        // Bypass: queue 2 and its engine both empty
        tick(4);
        send('{quick: 1'b0, kind: KIND_MANUAL, num: 6'h02});
        tick(3);
        chk("bypass", 32'h1, 32'(got_q[2].size()));
        rdchk("qstat2", OFF_QSTAT_BASE + 13'h8, RST_ZERO);
        // Mid-run reset must drop queue state and pending bits
        @(posedge clk);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        rdchk("qstat0 rst", OFF_QSTAT_BASE, RST_ZERO);
        rdchk("pend rst", {5'h00, OFF_PEND_LO}, RST_ZERO);
        finish_test();
    end
endmodule // tb_dma_interrupt_error_event_queues

`default_nettype wire
